// ===== hw/rfdiv_defs.svh
`ifndef RFDIV_DEFS_SVH
`define RFDIV_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define RFDIV_ADDR_INPUT_CLOCK_CONTROL 8'h33
`define RFDIV_ADDR_SYNTH_A_REF_DIVIDER 8'h34
`define RFDIV_ADDR_SYNTH_A_M_DIVIDER 8'h35
`define RFDIV_ADDR_SYNTH_B_REF_DIVIDER 8'h36

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RFDIV_BIT_REF_MUX_BYPASS 7
`define RFDIV_BIT_SEC_KEEP_ON 2
`define RFDIV_BIT_SEC_GAIN 1
`define RFDIV_BIT_PRI_GAIN 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RFDIV_RST_INPUT_CLOCK_CONTROL 8'h03
`define RFDIV_RST_SYNTH_A_REF_DIVIDER 3'h0
`define RFDIV_RST_SYNTH_A_M_DIVIDER 5'h00
`define RFDIV_RST_SYNTH_B_REF_DIVIDER 3'h0

`endif

// ===== hw/rfdiv_pkg.sv
package rfdiv_pkg;

    // Reference currently chosen by the input selector
    typedef enum logic [0:0]
    {
        RFDIV_REF_PRIMARY = 1'b0,
        RFDIV_REF_SECONDARY = 1'b1
    } rfdiv_ref_sel_t;

    // Stage divisor as driven to the synthesizer (1 means bypass)
    typedef logic [5:0] rfdiv_ratio_t;

endpackage

// ===== hw/rfdiv_config.sv
`timescale 1ns/100ps
`include "rfdiv_defs.svh"

// Functional notes
// [RULE1] Bypass bit set routes references around mux
// [RULE2] Bypass bit resets to zero, read-write
// [RULE3] Keep-on zero: secondary buffer off after return
// [RULE4] Keep-on one: secondary buffer stays powered (code keeps it on after return only while sec_in_use is high)
// [RULE5] Secondary gain: 0 minimum, 1 maximum, reset 1
// [RULE6] Primary gain: 0 minimum, 1 maximum, reset 1
// [RULE7] Synth A reference divider: 0 bypass, else code+1
// [RULE8] Synth A M divider: 0 bypass, else code+1
// [RULE9] Synth B reference divider: 0 bypass, else code+1
// [RULE10] Every intermediate code divides by code plus one
module rfdiv_config
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic nv_load,
    input wire logic [7:0] nv_input_clock_control,
    input wire logic [7:0] nv_synth_a_ref_divider,
    input wire logic [7:0] nv_synth_a_m_divider,
    input wire logic [7:0] nv_synth_b_ref_divider,
    input wire rfdiv_pkg::rfdiv_ref_sel_t ref_sel,
    input wire logic sec_in_use,
    output logic ref_mux_bypass,
    output logic sec_xtal_buf_en,
    output logic sec_buf_gain_a,
    output logic pri_buf_gain_b,
    output rfdiv_pkg::rfdiv_ratio_t synth_a_ref_ratio,
    output rfdiv_pkg::rfdiv_ratio_t synth_a_m_ratio,
    output rfdiv_pkg::rfdiv_ratio_t synth_b_ref_ratio
);
    import rfdiv_pkg::*;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] ctl_q;
    logic [2:0] a_rdiv_q;
    logic [4:0] a_mdiv_q;
    logic [2:0] b_rdiv_q;
    logic sel_s1_q;
    logic sel_s2_q;
    logic use_s1_q;
    logic use_s2_q;
    logic sec_buf_on_d;

    wire wr_ctl = reg_wr && (reg_addr == `RFDIV_ADDR_INPUT_CLOCK_CONTROL);
    wire wr_ard = reg_wr && (reg_addr == `RFDIV_ADDR_SYNTH_A_REF_DIVIDER);
    wire wr_amd = reg_wr && (reg_addr == `RFDIV_ADDR_SYNTH_A_M_DIVIDER);
    wire wr_brd = reg_wr && (reg_addr == `RFDIV_ADDR_SYNTH_B_REF_DIVIDER);

    // Control register; nonvolatile load wins over a software write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ctl_q <= `RFDIV_RST_INPUT_CLOCK_CONTROL; // RULE2 RULE5 RULE6
        else if (nv_load)
            ctl_q <= nv_input_clock_control;
        else if (wr_ctl)
            ctl_q <= reg_wdata; // RULE2
    end

    // Divider code registers, reserved upper bits not stored
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_rdiv_q <= `RFDIV_RST_SYNTH_A_REF_DIVIDER;
            a_mdiv_q <= `RFDIV_RST_SYNTH_A_M_DIVIDER;
            b_rdiv_q <= `RFDIV_RST_SYNTH_B_REF_DIVIDER;
        end
        else if (nv_load)
        begin
            a_rdiv_q <= nv_synth_a_ref_divider[2:0];
            a_mdiv_q <= nv_synth_a_m_divider[4:0];
            b_rdiv_q <= nv_synth_b_ref_divider[2:0];
        end
        else
        begin
            if (wr_ard)
                a_rdiv_q <= reg_wdata[2:0];
            if (wr_amd)
                a_mdiv_q <= reg_wdata[4:0];
            if (wr_brd)
                b_rdiv_q <= reg_wdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Read port: data one cycle after the strobe, zero otherwise
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `RFDIV_ADDR_INPUT_CLOCK_CONTROL: reg_rdata <= ctl_q;
                `RFDIV_ADDR_SYNTH_A_REF_DIVIDER: reg_rdata <= {5'h00, a_rdiv_q};
                `RFDIV_ADDR_SYNTH_A_M_DIVIDER: reg_rdata <= {3'h0, a_mdiv_q};
                `RFDIV_ADDR_SYNTH_B_REF_DIVIDER: reg_rdata <= {5'h00, b_rdiv_q};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // ----------------------------------------------------------------
    // Selector status comes from the input-select logic's domain
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
            use_s1_q <= 1'b0;
            use_s2_q <= 1'b0;
        end
        else
        begin
            sel_s1_q <= ref_sel;
            sel_s2_q <= sel_s1_q;
            use_s1_q <= sec_in_use;
            use_s2_q <= use_s1_q;
        end
    end

    // Secondary buffer power: on while secondary is selected; after a
    // return to primary it stays on only while keep-on and sec_in_use are both set
    always_comb
    begin
        sec_buf_on_d = 1'b0;
        if (sel_s2_q == RFDIV_REF_SECONDARY)
            sec_buf_on_d = 1'b1;
        else if (ctl_q[`RFDIV_BIT_SEC_KEEP_ON] && use_s2_q)
            sec_buf_on_d = 1'b1; // RULE4
        else
            sec_buf_on_d = 1'b0; // RULE3
    end

    // ----------------------------------------------------------------
    // Outputs to the analog front end, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_mux_bypass <= 1'b0;
            sec_xtal_buf_en <= 1'b0;
            sec_buf_gain_a <= 1'b1;
            pri_buf_gain_b <= 1'b1;
        end
        else
        begin
            ref_mux_bypass <= ctl_q[`RFDIV_BIT_REF_MUX_BYPASS]; // RULE1
            sec_xtal_buf_en <= sec_buf_on_d; // RULE3 RULE4
            sec_buf_gain_a <= ctl_q[`RFDIV_BIT_SEC_GAIN]; // RULE5
            pri_buf_gain_b <= ctl_q[`RFDIV_BIT_PRI_GAIN]; // RULE6
        end
    end

    // Divisor = code + 1; code 0 gives 1, i.e. bypass
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            synth_a_ref_ratio <= 6'h01;
            synth_a_m_ratio <= 6'h01;
            synth_b_ref_ratio <= 6'h01;
        end
        else
        begin
            synth_a_ref_ratio <= {3'h0, a_rdiv_q} + 6'h01; // RULE7 RULE10
            synth_a_m_ratio <= {1'b0, a_mdiv_q} + 6'h01; // RULE8 RULE10
            synth_b_ref_ratio <= {3'h0, b_rdiv_q} + 6'h01; // RULE9 RULE10
        end
    end

endmodule

// ===== testbench/rfdiv_checker.sv
`timescale 1ns/100ps
// -------------------------------
// Register to output relations
// -------------------------------
module rfdiv_checker
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic nv_load,
    input wire logic [7:0] nv_input_clock_control,
    input wire rfdiv_pkg::rfdiv_ref_sel_t ref_sel,
    input wire logic sec_in_use,
    input wire logic ref_mux_bypass,
    input wire logic sec_xtal_buf_en,
    input wire logic sec_buf_gain_a,
    input wire logic pri_buf_gain_b,
    input wire rfdiv_pkg::rfdiv_ratio_t synth_a_ref_ratio,
    input wire rfdiv_pkg::rfdiv_ratio_t synth_a_m_ratio,
    input wire rfdiv_pkg::rfdiv_ratio_t synth_b_ref_ratio
);
    import rfdiv_pkg::*;
    logic keep_q;
    // Shadow of the keep-on bit; nv load beats a write
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            keep_q <= 1'b0;
        else if (nv_load)
            keep_q <= nv_input_clock_control[2];
        else if (reg_wr && reg_addr == 8'h33)
            keep_q <= reg_wdata[2];
    // Read with no nv load racing it
    function automatic logic rd(input logic [7:0] a);
        return reg_rd && !nv_load && reg_addr == a;
    endfunction
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    bypass_out_a: assert property (rd(8'h33) |=> ref_mux_bypass == reg_rdata[7])
        else $error("bypass output differs");
    ctl_rw_a: assert property (reg_wr && !nv_load && reg_addr == 8'h33 ##1 rd(8'h33)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("control readback differs");
    sec_gain_a: assert property (rd(8'h33) |=> sec_buf_gain_a == reg_rdata[1])
        else $error("secondary gain differs");
    pri_gain_a: assert property (rd(8'h33) |=> pri_buf_gain_b == reg_rdata[0])
        else $error("primary gain differs");
    ref_a_ratio_a: assert property (rd(8'h34) |=> synth_a_ref_ratio == reg_rdata[5:0] + 6'h01)
        else $error("ref A ratio differs");
    m_ratio_a: assert property (rd(8'h35) |=> synth_a_m_ratio == reg_rdata[5:0] + 6'h01)
        else $error("M ratio differs");
    ref_b_ratio_a: assert property (rd(8'h36) |=> synth_b_ref_ratio == reg_rdata[5:0] + 6'h01)
        else $error("ref B ratio differs");
    sec_off_a: assert property ((!keep_q && ref_sel == RFDIV_REF_PRIMARY)[*4] |-> !sec_xtal_buf_en)
        else $error("secondary buffer left on");
    sec_keep_a: assert property ((keep_q && sec_in_use)[*4] ##0 sec_xtal_buf_en |=> sec_xtal_buf_en)
        else $error("secondary buffer dropped");
    cover property (rd(8'h35) ##1 synth_a_m_ratio == 6'h20);
    cover property (keep_q && sec_xtal_buf_en && ref_sel == RFDIV_REF_PRIMARY);
    cover property ($fell(sec_xtal_buf_en));
endmodule

bind rfdiv_config rfdiv_checker u_chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .nv_load, .nv_input_clock_control, .ref_sel, .sec_in_use, .ref_mux_bypass,
    .sec_xtal_buf_en, .sec_buf_gain_a, .pri_buf_gain_b, .synth_a_ref_ratio, .synth_a_m_ratio,
    .synth_b_ref_ratio);

// ===== testbench/ref_input_and_divider_config_bench.sv
`timescale 1ns/100ps
module ref_input_and_divider_config_bench;
    import rfdiv_pkg::*;
    logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, nv_load = 0, sec_in_use = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, n0 = 0, n1 = 0, n2 = 0, n3 = 0;
    logic ref_mux_bypass, sec_xtal_buf_en, sec_buf_gain_a, pri_buf_gain_b;
    rfdiv_ref_sel_t ref_sel = RFDIV_REF_PRIMARY;
    rfdiv_ratio_t synth_a_ref_ratio, synth_a_m_ratio, synth_b_ref_ratio;
    int checks = 0, fail_count = 0;
    always #20 clock = ~clock;
    rfdiv_config DUT (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .nv_load, .nv_input_clock_control(n0), .nv_synth_a_ref_divider(n1),
        .nv_synth_a_m_divider(n2), .nv_synth_b_ref_divider(n3), .ref_sel, .sec_in_use,
        .ref_mux_bypass, .sec_xtal_buf_en, .sec_buf_gain_a, .pri_buf_gain_b,
        .synth_a_ref_ratio, .synth_a_m_ratio, .synth_b_ref_ratio);
    // -------------------------------
    // Bus cycles and comparison
    // -------------------------------
    task automatic chk(input string n, input logic [7:0] s, e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Ends just past an edge, so the next call drives once per step
    task automatic wr(input logic [7:0] a, d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, e);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        #1 chk("rdata", reg_rdata, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Whole run is about 240 cycles, well under the 5000-cycle limit
    initial
    begin
        #200000 fail_count++;
        final_report;
    end
    // -------------------------------
    // Scenarios
    // -------------------------------
    initial
    begin
        settle(8);
        rst_n <= 1;
        chk("outs", {ref_mux_bypass, sec_xtal_buf_en, sec_buf_gain_a, pri_buf_gain_b}, 8'h03);
        rd(8'h33, 8'h03);
        for (int a = 8'h34; a < 8'h37; a++)
            rd(8'(a), 8'h00);
        // Reserved M divider bits are written as ones, synth B ones with the inverted code, and must read back zero
        for (int c = 0; c < 32; c++)
        begin
            wr(8'h35, 8'he0 | 8'(c));
            rd(8'h35, 8'(c));
            wr(8'h34, 8'(c));
            wr(8'h36, ~8'(c));
            rd(8'h36, {5'h0, ~3'(c)});
            settle(1);
            chk("m", synth_a_m_ratio, 8'(c + 1));
            chk("ra", synth_a_ref_ratio, 8'(c % 8 + 1));
            chk("rb", synth_b_ref_ratio, 8'(8 - c % 8));
        end
        wr(8'h33, 8'h80);
        rd(8'h33, 8'h80);
        chk("outs", {ref_mux_bypass, sec_buf_gain_a, pri_buf_gain_b}, 8'h04);
        wr(8'h33, 8'h7b);
        rd(8'h33, 8'h7b);
        wr(8'h33, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            ref_sel <= RFDIV_REF_SECONDARY;
            sec_in_use <= 1;
            settle(5);
            chk("sec on", sec_xtal_buf_en, 8'h01);
            ref_sel <= RFDIV_REF_PRIMARY;
            settle(5);
            chk("sec back", sec_xtal_buf_en, 8'(k));
            wr(8'h33, 8'h04);
        end
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        {n0, n1, n2, n3} <= 32'h81_06_1f_03;
        nv_load <= 1;
        wr(8'h34, 8'h05);
        nv_load <= 0;
        rd(8'h33, 8'h81);
        rd(8'h34, 8'h06);
        rd(8'h35, 8'h1f);
        rd(8'h36, 8'h03);
        final_report;
    end
endmodule
